// ==== src/bcvr_pkg.sv ====
// constants and carriers for the bridge config/verify register bank
package bcvr_pkg;
    // =========================================
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_MSB   = 15;
    localparam int ADDR_LSB   = 12;
    localparam int WR_BIT     = 11;
    localparam int DATA_MSB   = 10;
    localparam int DATA_LSB   = 1;

    // =========================================
    // register addresses
    localparam logic [3:0] ADDR_CFG3 = 4'h3;
    localparam logic [3:0] ADDR_CFG4 = 4'h4;
    localparam logic [3:0] ADDR_CFG5 = 4'h5;
    localparam logic [3:0] ADDR_CMD0 = 4'h6;
    localparam logic [3:0] ADDR_CMD1 = 4'h7;
    localparam logic [3:0] ADDR_RES0 = 4'h8;
    localparam logic [3:0] ADDR_RES1 = 4'h9;

    // =========================================
    // reset values, writable masks and the start kick mask
    localparam logic [9:0] CFG3_RST   = 10'h210;
    localparam logic [9:0] CFG4_RST   = 10'h060;
    localparam logic [9:0] CFG5_RST   = 10'h0f5;
    localparam logic [9:0] CMD0_RST   = 10'h000;
    localparam logic [9:0] CMD1_RST   = 10'h000;
    localparam logic [9:0] CFG5_MASK  = 10'h1f7;
    localparam logic [9:0] CMD1_MASK  = 10'h3ef;
    localparam logic [9:0] START_MASK = 10'h1ef;

    // =========================================
    // timing and scaling
    localparam int         CLK_PERIOD_NS = 50;
    localparam int         VDQ_STEP_NS   = 100;
    localparam int         VDQ_STEP_CYC  = (VDQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] OLT_STEP_MV   = 9'h019;
    localparam logic [4:0] BITCNT_SAT    = 5'h11;

    // =========================================
    // register carriers
    typedef struct packed {
        logic [3:0] onLoadThreshold;
        logic [5:0] drainFaultVerifyTime;
    } bcvr_cfg3_s;

    typedef struct packed {
        logic       onLoadDetectEn;
        logic       enableWatchdogOn;
        logic       offLoadTestCurrentSel;
        logic       gateRegLevelSel;
        logic [5:0] phaseCompThreshold;
    } bcvr_cfg4_s;

    typedef struct packed {
        logic       spareHi;
        logic       offLoadDetectDis;
        logic [3:0] senseOffsetSel;
        logic       spareLo;
        logic [2:0] senseGainSel;
    } bcvr_cfg5_s;

    typedef struct packed {
        logic offLoadPhaseSel;
        logic chkPhaseConnHigh;
        logic chkPhaseConnLow;
        logic chkDrainOver;
        logic chkOvercurrent;
        logic spare;
        logic chkGateUnder;
        logic chkOnLoad;
        logic chkOffLoadSource;
        logic chkOffLoadSink;
    } bcvr_cmd1_s;

    typedef struct packed {
        logic resPhaseBConn;
        logic resPhaseAConn;
        logic resBridgeSupplyDisc;
        logic resLowSrcBDisc;
        logic resLowSrcADisc;
    } bcvr_res0_s;

    typedef struct packed {
        logic resPhaseBState;
        logic resPhaseAState;
        logic resSenseBDisc;
        logic resSenseADisc;
    } bcvr_res1_s;
endpackage

// ==== src/bcvr_regs.sv ====
// serial-access configuration and verification register bank
`timescale 1ns/1ps
`default_nettype none

module bcvr_regs
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // serial port
    input  wire logic                 strobeN,
    input  wire logic                 sck,
    input  wire logic                 sdi,
    output logic                      sdo,
    output logic                      sdoEn,
    output logic                      frameError,
    // configuration
    output bcvr_pkg::bcvr_cfg3_s      loadCfg,
    output bcvr_pkg::bcvr_cfg4_s      thrCfg,
    output bcvr_pkg::bcvr_cfg5_s      ampCfg,
    output logic [9:0]                supplyVerify,
    output bcvr_pkg::bcvr_cmd1_s      bridgeVerify,
    output bcvr_pkg::bcvr_cmd1_s      bridgeVerifyStart,
    // decoded settings
    output logic [8:0]                onLoadThresholdMv,
    output logic [6:0]                drainVerifyCycles,
    output logic [5:0]                senseGain,
    output logic [11:0]               senseOffsetMv,
    // monitor results
    input  wire bcvr_pkg::bcvr_res0_s connectRes,
    input  wire bcvr_pkg::bcvr_res1_s phaseRes
);

    // =========================================
    // lookup tables
    function automatic logic [11:0] offsetMv(input logic [3:0] code);
        logic [11:0] mv;
        mv = 12'h000;
        unique case (code)
            4'h0, 4'h1: mv = 12'h000;
            4'h2, 4'h3: mv = 12'h064;
            4'h4:       mv = 12'h0c8;
            4'h5:       mv = 12'h12c;
            4'h6:       mv = 12'h190;
            4'h7:       mv = 12'h1f4;
            4'h8:       mv = 12'h2ee;
            4'h9:       mv = 12'h3e8;
            4'ha:       mv = 12'h4e2;
            4'hb:       mv = 12'h5dc;
            4'hc:       mv = 12'h6d6;
            4'hd:       mv = 12'h7d0;
            4'he:       mv = 12'h8ca;
            4'hf:       mv = 12'h9c4;
        endcase
        return mv;
    endfunction

    function automatic logic [5:0] gainOf(input logic [2:0] code);
        logic [5:0] g;
        g = 6'h00;
        unique case (code)
            3'h0: g = 6'h0a;
            3'h1: g = 6'h0f;
            3'h2: g = 6'h14;
            3'h3: g = 6'h19;
            3'h4: g = 6'h1e;
            3'h5: g = 6'h23;
            3'h6: g = 6'h28;
            3'h7: g = 6'h32;
        endcase
        return g;
    endfunction

    // =========================================
    // reset release
    logic rstMeta_reg;
    logic rstSync;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_reg <= 1'b0;
            rstSync     <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstSync     <= rstMeta_reg;
        end
    end

    // =========================================
    // serial edges and frame decode
    logic        sckQ_reg;
    logic        strobeQ_reg;
    logic        armed_reg;
    logic [15:0] rxShift_reg;
    logic [4:0]  bitCnt_reg;
    logic [15:0] txShift_reg;
    logic [3:0]  rdAddr_reg;
    logic        sdoEn_reg;
    logic        frameError_reg;

    wire         sckRise    = sck & ~sckQ_reg;
    wire         sckFall    = ~sck & sckQ_reg;
    wire         frameStart = ~strobeN & strobeQ_reg & armed_reg;
    wire         frameEnd   = strobeN & ~strobeQ_reg & armed_reg;
    wire         inFrame    = ~strobeN & armed_reg;
    wire [3:0]   rxAddr     = rxShift_reg[bcvr_pkg::ADDR_MSB:bcvr_pkg::ADDR_LSB];
    wire         rxWr       = rxShift_reg[bcvr_pkg::WR_BIT];
    wire [9:0]   rxData     = rxShift_reg[bcvr_pkg::DATA_MSB:bcvr_pkg::DATA_LSB];
    wire         parityOk   = ^rxShift_reg;
    wire         lenOk      = bitCnt_reg == 5'(bcvr_pkg::FRAME_BITS);
    wire         commit     = frameEnd & parityOk & lenOk;
    wire         wrCommit   = commit & rxWr;

    // register selects
    wire         wrCfg3 = wrCommit & (rxAddr == bcvr_pkg::ADDR_CFG3);
    wire         wrCfg4 = wrCommit & (rxAddr == bcvr_pkg::ADDR_CFG4);
    wire         wrCfg5 = wrCommit & (rxAddr == bcvr_pkg::ADDR_CFG5);
    wire         wrCmd0 = wrCommit & (rxAddr == bcvr_pkg::ADDR_CMD0);
    wire         wrCmd1 = wrCommit & (rxAddr == bcvr_pkg::ADDR_CMD1);

    // a frame already running when reset lifts is not trusted
    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
            armed_reg <= 1'b0;
        else if (strobeN)
            armed_reg <= 1'b1;
    end

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            sckQ_reg    <= 1'b1;
            strobeQ_reg <= 1'b1;
        end
        else
        begin
            sckQ_reg    <= sck;
            strobeQ_reg <= strobeN;
        end
    end

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            rxShift_reg <= 16'h0000;
            bitCnt_reg  <= 5'h00;
        end
        else if (frameStart)
        begin
            rxShift_reg <= 16'h0000;
            bitCnt_reg  <= 5'h00;
        end
        else if (inFrame && sckRise)
        begin
            rxShift_reg <= {rxShift_reg[14:0], sdi};
            if (bitCnt_reg != bcvr_pkg::BITCNT_SAT)
                bitCnt_reg <= bitCnt_reg + 5'h01;
        end
    end

    // =========================================
    // registers
    bcvr_pkg::bcvr_cfg3_s cfg3_reg;
    bcvr_pkg::bcvr_cfg4_s cfg4_reg;
    bcvr_pkg::bcvr_cfg5_s cfg5_reg;
    logic [9:0]           cmd0_reg;
    bcvr_pkg::bcvr_cmd1_s cmd1_reg;
    bcvr_pkg::bcvr_cmd1_s start_reg;
    bcvr_pkg::bcvr_res0_s res0_reg;
    bcvr_pkg::bcvr_res1_s res1_reg;

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            cfg3_reg <= bcvr_pkg::CFG3_RST;
            cfg4_reg <= bcvr_pkg::CFG4_RST;
            cfg5_reg <= bcvr_pkg::CFG5_RST;
            cmd0_reg <= bcvr_pkg::CMD0_RST;
            cmd1_reg <= bcvr_pkg::CMD1_RST;
        end
        else
        begin
            if (wrCfg3)
                cfg3_reg <= rxData;
            if (wrCfg4)
                cfg4_reg <= rxData;
            if (wrCfg5)
                cfg5_reg <= rxData & bcvr_pkg::CFG5_MASK;
            if (wrCmd0)
                cmd0_reg <= rxData;
            if (wrCmd1)
                cmd1_reg <= rxData & bcvr_pkg::CMD1_MASK;
        end
    end

    // start is a single-cycle kick; the phase select bit never kicks
    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
            start_reg <= '0;
        else
            start_reg <= wrCmd1 ? (rxData & bcvr_pkg::START_MASK) : '0;
    end

    // results are sampled every cycle; writes never reach them
    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            res0_reg <= '0;
            res1_reg <= '0;
        end
        else
        begin
            res0_reg <= connectRes;
            res1_reg <= phaseRes;
        end
    end

    // =========================================
    // reply: register named by the previous good frame
    logic [9:0] replyData;
    wire  [9:0] res0Data = {4'h0, res0_reg[4:2], 1'b0, res0_reg[1:0]};
    wire  [9:0] res1Data = {5'h00, res1_reg[3:2], 1'b0, res1_reg[1:0]};

    always_comb
    begin
        unique case (rdAddr_reg)
            bcvr_pkg::ADDR_CFG3: replyData = cfg3_reg;
            bcvr_pkg::ADDR_CFG4: replyData = cfg4_reg;
            bcvr_pkg::ADDR_CFG5: replyData = cfg5_reg;
            bcvr_pkg::ADDR_CMD0: replyData = cmd0_reg;
            bcvr_pkg::ADDR_CMD1: replyData = cmd1_reg;
            bcvr_pkg::ADDR_RES0: replyData = res0Data;
            bcvr_pkg::ADDR_RES1: replyData = res1Data;
            default:             replyData = 10'h000;
        endcase
    end

    wire [15:0] replyWord = {rdAddr_reg, 1'b0, replyData, ~^{rdAddr_reg, replyData}};

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            txShift_reg    <= 16'h0000;
            rdAddr_reg     <= bcvr_pkg::ADDR_CFG3;
            sdoEn_reg      <= 1'b0;
            frameError_reg <= 1'b0;
        end
        else
        begin
            sdoEn_reg <= inFrame;
            if (frameStart)
                txShift_reg <= replyWord;
            else if (inFrame && sckFall)
                txShift_reg <= {txShift_reg[14:0], 1'b0};
            if (commit)
                rdAddr_reg <= rxAddr;
            if (frameEnd)
                frameError_reg <= ~(parityOk & lenOk);
        end
    end

    // =========================================
    // decoded settings
    logic [8:0]  oltMv_reg;
    logic [6:0]  tvdCyc_reg;
    logic [5:0]  gain_reg;
    logic [11:0] offMv_reg;

    wire [8:0] oltMvNext = 9'(({5'h00, cfg3_reg.onLoadThreshold} + 9'h001) * bcvr_pkg::OLT_STEP_MV);
    wire [6:0] tvdNext   = 7'({1'b0, cfg3_reg.drainFaultVerifyTime} * 7'(bcvr_pkg::VDQ_STEP_CYC));

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            oltMv_reg  <= 9'h000;
            tvdCyc_reg <= 7'h00;
            gain_reg   <= 6'h00;
            offMv_reg  <= 12'h000;
        end
        else
        begin
            oltMv_reg  <= oltMvNext;
            tvdCyc_reg <= tvdNext;
            gain_reg   <= gainOf(cfg5_reg.senseGainSel);
            offMv_reg  <= offsetMv(cfg5_reg.senseOffsetSel);
        end
    end

    // =========================================
    // outputs
    assign sdo               = txShift_reg[15];
    assign sdoEn             = sdoEn_reg;
    assign frameError        = frameError_reg;
    assign loadCfg           = cfg3_reg;
    assign thrCfg            = cfg4_reg;
    assign ampCfg            = cfg5_reg;
    assign supplyVerify      = cmd0_reg;
    assign bridgeVerify      = cmd1_reg;
    assign bridgeVerifyStart = start_reg;
    assign onLoadThresholdMv = oltMv_reg;
    assign drainVerifyCycles = tvdCyc_reg;
    assign senseGain         = gain_reg;
    assign senseOffsetMv     = offMv_reg;

    // =========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync);

    sequence s_badParity;
        frameEnd && lenOk && !parityOk;
    endsequence

    sequence s_wrCmd1;
        wrCmd1;
    endsequence

    property p_parity_reject;
        s_badParity |=> frameError_reg && $stable(cfg3_reg) && $stable(cmd1_reg);
    endproperty
    a_parity_reject: assert property (p_parity_reject) else $error("bad parity frame accepted");

    property p_reply_parity;
        frameStart |=> (^txShift_reg) && txShift_reg[11] == 1'b0;
    endproperty
    a_reply_parity: assert property (p_reply_parity) else $error("reply frame malformed");

    property p_olt_mv;
        $changed(cfg3_reg.onLoadThreshold) |=> onLoadThresholdMv == 9'(($past(cfg3_reg.onLoadThreshold) + 9'h001) * 9'h019);
    endproperty
    a_olt_mv: assert property (p_olt_mv) else $error("on-load threshold wrong");

    property p_tvd_cyc;
        rstSync |=> drainVerifyCycles == 7'({1'b0, $past(cfg3_reg.drainFaultVerifyTime)} * 7'h02);
    endproperty
    a_tvd_cyc: assert property (p_tvd_cyc) else $error("verify time count wrong");

    property p_cfg4_write;
        wrCfg4 |=> thrCfg == $past(rxData) ##1 $stable(thrCfg) || $past(wrCfg4);
    endproperty
    a_cfg4_write: assert property (p_cfg4_write) else $error("config write lost");

    property p_gain;
        cfg5_reg.senseGainSel == 3'h7 |=> senseGain == 6'h32;
    endproperty
    a_gain: assert property (p_gain) else $error("gain table wrong");

    property p_offset;
        cfg5_reg.senseOffsetSel == 4'h8 |=> senseOffsetMv == 12'h2ee;
    endproperty
    a_offset: assert property (p_offset) else $error("offset table wrong");

    property p_doo;
        wrCfg5 |=> ampCfg.offLoadDetectDis == $past(rxData[8]);
    endproperty
    a_doo: assert property (p_doo) else $error("detect disable not stored");

    property p_cmd0;
        wrCmd0 |=> supplyVerify == $past(rxData);
    endproperty
    a_cmd0: assert property (p_cmd0) else $error("supply verify not stored");

    property p_start;
        s_wrCmd1 |=> bridgeVerifyStart == ($past(rxData) & 10'h1ef) ##1 bridgeVerifyStart == '0;
    endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");

    property p_phase_sel;
        s_wrCmd1 |=> bridgeVerify.offLoadPhaseSel == $past(rxData[9]) && !bridgeVerifyStart.offLoadPhaseSel;
    endproperty
    a_phase_sel: assert property (p_phase_sel) else $error("phase select wrong");

    property p_results;
        rstSync |=> res0_reg == $past(connectRes) && res1_reg == $past(phaseRes);
    endproperty
    a_results: assert property (p_results) else $error("result not tracking monitor");

    property p_reset_defaults;
        $rose(rstSync) |-> cfg3_reg == 10'h210 && cfg4_reg == 10'h060 && cfg5_reg == 10'h0f5 && !armed_reg;
    endproperty
    a_reset_defaults: assert property (@(posedge clk) disable iff (!rst_n) p_reset_defaults) else $error("defaults lost");

endmodule

`default_nettype wire

// ==== verification/bcvr_serial_master.sv ====
// serial master model that drives frames into the register bank
`timescale 1ns/1ps
`default_nettype none

module bcvr_serial_master
(
    // clock
    input  wire logic clk,
    // serial lines
    output logic      strobeN,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    // =========================================
    // frame transfer, msb first, sck idle high
    initial
    begin
        strobeN = 1'b1;
        sck     = 1'b1;
        sdi     = 1'b0;
    end

    // hold sets each sck level in clocks; 2 is the fastest legal pace
    task automatic xfer(input logic [15:0] tx, input int nbits, input int hold, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk);
        strobeN <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            repeat (hold) @(posedge clk);
            // reply bit still stands here; the device moves on after the fall
            rx = {rx[14:0], sdo};
            sdi <= (i < 16) ? tx[15 - i] : 1'b1;
            sck <= 1'b0;
            repeat (hold) @(posedge clk);
            sck <= 1'b1;
        end
        repeat (hold) @(posedge clk);
        strobeN <= 1'b1;
        // no pull on the data line: show the inverse once released
        sdi <= ~sdi;
        repeat (4) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the config and verify register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 strobeN;
    logic                 sck;
    logic                 sdi;
    logic                 sdo;
    logic                 sdoEn;
    logic                 frameError;
    bcvr_pkg::bcvr_cfg3_s loadCfg;
    bcvr_pkg::bcvr_cfg4_s thrCfg;
    bcvr_pkg::bcvr_cfg5_s ampCfg;
    logic [9:0]           supplyVerify;
    bcvr_pkg::bcvr_cmd1_s bridgeVerify;
    bcvr_pkg::bcvr_cmd1_s bridgeVerifyStart;
    logic [8:0]           onLoadThresholdMv;
    logic [6:0]           drainVerifyCycles;
    logic [5:0]           senseGain;
    logic [11:0]          senseOffsetMv;
    bcvr_pkg::bcvr_res0_s connectRes = 5'h00;
    bcvr_pkg::bcvr_res1_s phaseRes = 4'h0;
    int                   seed = 32'hb2a830d1;
    int                   err_total = 0;
    int                   cmp_count = 0;
    int                   cyc = 0;
    int                   startCnt = 0;
    int                   enHits = 0;
    int                   k0;
    logic [9:0]           startLast = 10'h000;
    logic [15:0]          rx;
    logic [9:0]           d3, d4, d5;
    logic [4:0]           r0;
    logic [3:0]           r1;

    always #25 clk = ~clk;

    bcvr_regs i_dut
    (
        .clk               (clk),
        .rst_n             (rst_n),
        .strobeN           (strobeN),
        .sck               (sck),
        .sdi               (sdi),
        .sdo               (sdo),
        .sdoEn             (sdoEn),
        .frameError        (frameError),
        .loadCfg           (loadCfg),
        .thrCfg            (thrCfg),
        .ampCfg            (ampCfg),
        .supplyVerify      (supplyVerify),
        .bridgeVerify      (bridgeVerify),
        .bridgeVerifyStart (bridgeVerifyStart),
        .onLoadThresholdMv (onLoadThresholdMv),
        .drainVerifyCycles (drainVerifyCycles),
        .senseGain         (senseGain),
        .senseOffsetMv     (senseOffsetMv),
        .connectRes        (connectRes),
        .phaseRes          (phaseRes)
    );

    bcvr_serial_master i_master
    (
        .clk     (clk),
        .strobeN (strobeN),
        .sck     (sck),
        .sdi     (sdi),
        .sdo     (sdo)
    );

    // =========================================
    // start pulse monitor and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sdoEn === 1'b1)
            enHits <= enHits + 1;
        if (bridgeVerifyStart !== 10'h000)
        begin
            startCnt  <= startCnt + 1;
            startLast <= bridgeVerifyStart;
        end
        if (cyc == 40000)
        begin
            err_total++;
            stop_test();
        end
    end

    // =========================================
    // expectations
    function automatic logic [15:0] frame(input logic [3:0] a, input logic w, input logic [9:0] d);
        return {a, w, d, ~^{a, w, d}};
    endfunction

    function automatic logic [15:0] olMv(input logic [3:0] n);
        return 16'((int'(n) + 1) * 25);
    endfunction

    function automatic logic [15:0] vdCyc(input logic [5:0] n);
        return 16'(int'(n) * 100 / 50);
    endfunction

    function automatic logic [15:0] gainOf(input logic [2:0] n);
        return 16'(n == 3'h7 ? 50 : 10 + 5 * int'(n));
    endfunction

    function automatic logic [15:0] offMv(input logic [3:0] n);
        int v;
        v = int'(n);
        return 16'(v < 2 ? 0 : v < 4 ? 100 : v < 8 ? (v - 2) * 100 : v == 8 ? 750 : 1000 + (v - 9) * 250);
    endfunction

    // =========================================
    // frame tasks and compare
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic access(input logic [3:0] a, input logic w, input logic [9:0] d, output logic [15:0] r);
        int hold;
        int en0;
        hold = 2 + int'($unsigned($random(seed)) % 3);
        en0 = enHits;
        i_master.xfer(frame(a, w, d), 16, hold, r);
        check16({15'h0000, ^r}, 16'h0001);
        check16({15'h0000, frameError}, 16'h0000);
        check16({15'h0000, sdoEn}, 16'h0000);
        check16(16'(enHits - en0), 16'(33 * hold));
    endtask

    task automatic wr(input logic [3:0] a, input logic [9:0] d);
        logic [15:0] r;
        access(a, 1'b1, d, r);
    endtask

    // reply comes one frame late, so address the same place twice
    task automatic rd(input logic [3:0] a, input logic [9:0] d);
        logic [15:0] r;
        access(a, 1'b0, 10'h000, r);
        access(a, 1'b0, 10'h000, r);
        check16(r, frame(a, 1'b0, d));
    endtask

    task automatic bad(input logic [15:0] tx, input int n);
        logic [15:0] r;
        i_master.xfer(tx, n, 2, r);
        check16({15'h0000, frameError}, 16'h0001);
    endtask

    task automatic chk_defaults();
        check16({6'h00, loadCfg}, {6'h00, 4'h8, 6'h10});
        check16({6'h00, thrCfg}, {6'h00, 4'h1, 6'h20});
        check16({6'h00, ampCfg}, {6'h00, 2'h0, 4'hf, 1'b0, 3'h5});
        check16({6'h00, supplyVerify}, 16'h0000);
        check16({6'h00, bridgeVerify}, 16'h0000);
        check16({7'h00, onLoadThresholdMv}, olMv(4'h8));
        check16({9'h000, drainVerifyCycles}, vdCyc(6'h10));
        check16({10'h000, senseGain}, gainOf(3'h5));
        check16({4'h0, senseOffsetMv}, offMv(4'hf));
        access(4'h4, 1'b0, 10'h000, rx);
        check16(rx, frame(4'h3, 1'b0, {4'h8, 6'h10}));
    endtask

    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // =========================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk_defaults();
        for (int k = 0; k < 10; k++)
        begin
            d3 = (k < 2) ? {10{k == 0}} : 10'($random(seed));
            d4 = (k < 2) ? {10{k == 0}} : 10'($random(seed));
            d5 = (k < 2) ? {10{k == 0}} : 10'($random(seed));
            wr(4'h3, d3);
            wr(4'h4, d4);
            wr(4'h5, d5);
            check16({6'h00, loadCfg}, {6'h00, d3});
            check16({6'h00, thrCfg}, {6'h00, d4});
            check16({6'h00, ampCfg}, {6'h00, d5 & 10'h1f7});
            check16({7'h00, onLoadThresholdMv}, olMv(d3[9:6]));
            check16({9'h000, drainVerifyCycles}, vdCyc(d3[5:0]));
            rd(4'h5, d5 & 10'h1f7);
        end
        for (int k = 0; k < 16; k++)
        begin
            wr(4'h5, {2'h0, 4'(k), 1'b0, 3'(k)});
            check16({4'h0, senseOffsetMv}, offMv(4'(k)));
            check16({10'h000, senseGain}, gainOf(3'(k)));
        end
        d5 = 10'($random(seed));
        wr(4'h6, d5);
        check16({6'h00, supplyVerify}, {6'h00, d5});
        rd(4'h6, d5);
        k0 = startCnt;
        wr(4'h7, 10'h3ff);
        check16({6'h00, bridgeVerify}, 16'h03ef);
        check16(16'(startCnt - k0), 16'h0001);
        check16({6'h00, startLast}, 16'h01ef);
        k0 = startCnt;
        wr(4'h7, 10'h200);
        check16({6'h00, bridgeVerify}, 16'h0200);
        check16(16'(startCnt - k0), 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            r0 = 5'($random(seed));
            r1 = 4'($random(seed));
            connectRes <= r0;
            phaseRes   <= r1;
            wr(4'h8, 10'h3ff);
            wr(4'h9, 10'h3ff);
            rd(4'h8, {4'h0, r0[4:2], 1'b0, r0[1:0]});
            rd(4'h9, {5'h00, r1[3:2], 1'b0, r1[1:0]});
        end
        wr(4'hc, 10'h3ff);
        rd(4'hc, 10'h000);
        // refused frames must leave data and the reply pointer alone
        access(4'h5, 1'b0, 10'h000, rx);
        bad(frame(4'h4, 1'b1, 10'h155) ^ 16'h0001, 16);
        bad(frame(4'h4, 1'b1, 10'h155), 15);
        bad(frame(4'h4, 1'b1, 10'h155), 17);
        access(4'h4, 1'b0, 10'h000, rx);
        check16(rx, frame(4'h5, 1'b0, {2'h0, 4'hf, 1'b0, 3'h7}));
        check16({6'h00, thrCfg}, {6'h00, d4});
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk_defaults();
        stop_test();
    end
endmodule

`default_nettype wire
